// ### design/tbpec_core.sv
// Contract
// - Stop select 00: on suspend, halt after the next count step.
// - Stop select 01: finish the cycle; up mode halts at period.
// - Stop select 01: down and up-down modes halt at zero.
// - Stop select 1X: counter runs free, suspend ignored.
// - Phase direction bit matters only in up-down mode.
// - Up-down: after phase load, count down on 0, up on 1.
// - Tick rate is system clock over high times low prescale ratio.
// - Low prescale 000..111 gives /1 to /128; reset 000.
// - High prescale codes give /1,/2,/4../14; reset 001.
// - Phase load enabled: sync loads phase; disabled: sync ignored.
`timescale 1ns/1ps
module tbpec_core
	import tbpec_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	// Register port
	input  wire logic [3:0]  I_ADDR,
	input  wire logic [15:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [15:0] O_RDATA,
	// Debug and sync pins
	input  wire logic        I_EMU_SUSPEND,
	input  wire logic        I_SYNC_IN,
	// Time-base state
	output logic      [15:0] O_TIMEBASE_COUNT,
	output logic             O_TIMEBASE_TICK,
	output logic             O_COUNT_UP,
	output logic             O_HALTED
);
	logic [15:0] control_reg;
	logic [15:0] period_reg;
	logic [15:0] phase_reg;
	logic [15:0] count_reg;
	logic        up_reg;
	logic        susp_meta_reg;
	logic        susp_reg;
	logic        sync_meta_reg;
	logic        sync_reg;
	logic        sync_prev_reg;
	tbpec_emu_e  emu_reg;
	tbpec_emu_e  emu_next;
	logic        tick;
	logic        sync_evt;
	logic        step;
	logic        step_en;
	logic [15:0] count_next;
	logic        up_next;
	logic [1:0]  mode;
	logic [1:0]  emu_sel;

	assign mode    = control_reg[MODE_MSB:MODE_LSB];
	assign emu_sel = control_reg[EMU_MSB:EMU_LSB];

	tbpec_prescaler u_prescaler (
		.i_clk                 (I_CLK),
		.i_rst_n               (I_RST_N),
		.i_high_speed_prescale (control_reg[HSP_MSB:HSP_LSB]),
		.i_low_speed_prescale  (control_reg[LSP_MSB:LSP_LSB]),
		.o_timebase_tick       (tick)
	);

	// Pins from outside the clock domain pass two flops
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			susp_meta_reg <= 1'b0;
			susp_reg      <= 1'b0;
			sync_meta_reg <= 1'b0;
			sync_reg      <= 1'b0;
			sync_prev_reg <= 1'b0;
		end else begin
			susp_meta_reg <= I_EMU_SUSPEND;
			susp_reg      <= susp_meta_reg;
			sync_meta_reg <= I_SYNC_IN;
			sync_reg      <= sync_meta_reg;
			sync_prev_reg <= sync_reg;
		end
	end

	// Sync is a rising edge of the synchronised pin
	assign sync_evt = sync_reg && !sync_prev_reg;

	// Counter steps on a tick unless frozen mode or halted
	assign step_en = (mode != MODE_FROZEN) && (emu_reg != TBPEC_HALTED);
	assign step    = tick && step_en;

	// Register writes
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			control_reg <= CONTROL_RST;
			period_reg  <= PERIOD_RST;
			phase_reg   <= PHASE_RST;
		end else if (I_WR) begin
			unique case (I_ADDR)
				ADDR_CONTROL: control_reg <= I_WDATA;
				ADDR_PERIOD:  period_reg  <= I_WDATA;
				ADDR_PHASE:   phase_reg   <= I_WDATA;
				default: ;
			endcase
		end
	end

	// Next count and direction
	always_comb begin
		count_next = count_reg;
		up_next    = up_reg;
		// Fixed-direction modes show their direction even while halted
		if (mode == MODE_UP) begin
			up_next = 1'b1;
		end else if (mode == MODE_DOWN) begin
			up_next = 1'b0;
		end
		if (step) begin
			unique case (mode)
				MODE_UP: begin
					up_next = 1'b1;
					if (count_reg >= period_reg) begin
						count_next = COUNT_ZERO;
					end else begin
						count_next = count_reg + COUNT_ONE;
					end
				end
				MODE_DOWN: begin
					up_next = 1'b0;
					if (count_reg == COUNT_ZERO) begin
						count_next = period_reg;
					end else begin
						count_next = count_reg - COUNT_ONE;
					end
				end
				MODE_UPDOWN: begin
					if (up_reg) begin
						if (count_reg >= period_reg) begin
							up_next    = 1'b0;
							count_next = count_reg - COUNT_ONE;
						end else begin
							count_next = count_reg + COUNT_ONE;
						end
					end else begin
						if (count_reg == COUNT_ZERO) begin
							up_next    = 1'b1;
							count_next = count_reg + COUNT_ONE;
						end else begin
							count_next = count_reg - COUNT_ONE;
						end
					end
				end
				default: ;
			endcase
		end
		// Sync load overrides a step in the same cycle
		if (sync_evt && control_reg[PHEN_BIT]) begin
			count_next = phase_reg;
			if (mode == MODE_UPDOWN) begin
				up_next = control_reg[PHDIR_BIT];
			end
		end
		// A software write to the count wins over everything
		if (I_WR && I_ADDR == ADDR_COUNT) begin
			count_next = I_WDATA;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			count_reg <= COUNT_RST;
			up_reg    <= 1'b1;
		end else begin
			count_reg <= count_next;
			up_reg    <= up_next;
		end
	end

	// Emulation stop sequencing; checks the value the counter moves to
	always_comb begin
		emu_next = emu_reg;
		unique case (emu_reg)
			TBPEC_RUN: begin
				if (susp_reg && !emu_sel[1]) begin
					emu_next = TBPEC_STOPPING;
				end
			end
			TBPEC_STOPPING: begin
				if (!susp_reg || emu_sel[1]) begin
					emu_next = TBPEC_RUN;
				end else if (step) begin
					if (emu_sel == EMU_NEXT_STEP) begin
						emu_next = TBPEC_HALTED;
					end else if (mode == MODE_UP) begin
						if (count_next == period_reg) begin
							emu_next = TBPEC_HALTED;
						end
					end else if (count_next == COUNT_ZERO) begin
						emu_next = TBPEC_HALTED;
					end
				end
			end
			TBPEC_HALTED: begin
				if (!susp_reg || emu_sel[1]) begin
					emu_next = TBPEC_RUN;
				end
			end
			default: emu_next = TBPEC_RUN;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			emu_reg <= TBPEC_RUN;
		end else begin
			emu_reg <= emu_next;
		end
	end

	// Outputs straight from flops
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_TIMEBASE_COUNT <= COUNT_RST;
			O_TIMEBASE_TICK  <= 1'b0;
			O_COUNT_UP       <= 1'b1;
			O_HALTED         <= 1'b0;
		end else begin
			O_TIMEBASE_COUNT <= count_next;
			O_TIMEBASE_TICK  <= tick;
			O_COUNT_UP       <= up_next;
			O_HALTED         <= (emu_next == TBPEC_HALTED);
		end
	end

	// Read data in the cycle after the strobe only
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_RDATA <= ZERO16;
		end else if (I_RD) begin
			unique case (I_ADDR)
				ADDR_CONTROL: O_RDATA <= control_reg;
				ADDR_PERIOD:  O_RDATA <= period_reg;
				ADDR_PHASE:   O_RDATA <= phase_reg;
				ADDR_COUNT:   O_RDATA <= count_reg;
				ADDR_STATUS:  O_RDATA <= {12'h000, up_reg,
					emu_reg == TBPEC_HALTED,
					emu_reg == TBPEC_STOPPING, susp_reg};
				default:      O_RDATA <= ZERO16;
			endcase
		end else begin
			O_RDATA <= ZERO16;
		end
	end
endmodule : tbpec_core

// ### design/tbpec_pkg.sv
package tbpec_pkg;
	// Register indices on the plain register port (word index = address)
	localparam logic [3:0]  ADDR_CONTROL = 4'h0;
	localparam logic [3:0]  ADDR_PERIOD  = 4'h1;
	localparam logic [3:0]  ADDR_PHASE   = 4'h2;
	localparam logic [3:0]  ADDR_COUNT   = 4'h3;
	localparam logic [3:0]  ADDR_STATUS  = 4'h4;
	// Field positions of the time-base control register
	localparam int          EMU_MSB      = 15;
	localparam int          EMU_LSB      = 14;
	localparam int          PHDIR_BIT    = 13;
	localparam int          LSP_MSB      = 12;
	localparam int          LSP_LSB      = 10;
	localparam int          HSP_MSB      = 9;
	localparam int          HSP_LSB      = 7;
	localparam int          PHEN_BIT     = 2;
	localparam int          MODE_MSB     = 1;
	localparam int          MODE_LSB     = 0;
	// Reset values and count constants
	localparam logic [15:0] CONTROL_RST  = 16'h0083;
	localparam logic [15:0] PERIOD_RST   = 16'h0000;
	localparam logic [15:0] PHASE_RST    = 16'h0000;
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic [15:0] COUNT_ZERO   = 16'h0000;
	localparam logic [15:0] COUNT_ONE    = 16'h0001;
	localparam logic [15:0] ZERO16       = 16'h0000;
	// Emulation stop selections
	localparam logic [1:0]  EMU_NEXT_STEP = 2'h0;
	localparam logic [1:0]  EMU_FULL_CYCLE = 2'h1;
	// Counter modes
	localparam logic [1:0]  MODE_UP      = 2'h0;
	localparam logic [1:0]  MODE_DOWN    = 2'h1;
	localparam logic [1:0]  MODE_UPDOWN  = 2'h2;
	localparam logic [1:0]  MODE_FROZEN  = 2'h3;
	// Prescaler counter width (largest total ratio 14 x 128)
	localparam int          PRE_W        = 11;
	localparam logic [PRE_W-1:0] PRE_ONE = 11'h001;
	localparam logic [PRE_W-1:0] PRE_ZERO = 11'h000;
	localparam logic [3:0]  HSP_ONE      = 4'h1;
	localparam logic [3:0]  HSP_ODD      = 4'h1;

	typedef enum logic [1:0] {
		TBPEC_RUN    = 2'b00,
		TBPEC_STOPPING = 2'b01,
		TBPEC_HALTED = 2'b10
	} tbpec_emu_e;
endpackage : tbpec_pkg

// ### design/tbpec_prescaler.sv
`timescale 1ns/1ps
module tbpec_prescaler
	import tbpec_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Divisor fields
	input  wire logic [2:0] i_high_speed_prescale,
	input  wire logic [2:0] i_low_speed_prescale,
	// Tick enable out
	output logic            o_timebase_tick
);
	logic [PRE_W-1:0] count_reg;
	logic [PRE_W-1:0] ratio_next;
	logic [3:0]       hsp_div;

	// Code 0 is /1, otherwise twice the code
	always_comb begin
		if (i_high_speed_prescale == 3'h0) begin
			hsp_div = HSP_ONE;
		end else begin
			hsp_div = {i_high_speed_prescale, 1'b0};
		end
		ratio_next = PRE_W'(hsp_div) << i_low_speed_prescale;
	end

	// A ratio change applies at once; a count already at or past the new terminal count ticks on the next clock
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			count_reg       <= PRE_ZERO;
			o_timebase_tick <= 1'b0;
		end else if (count_reg >= ratio_next - PRE_ONE) begin
			count_reg       <= PRE_ZERO;
			o_timebase_tick <= 1'b1;
		end else begin
			count_reg       <= count_reg + PRE_ONE;
			o_timebase_tick <= 1'b0;
		end
	end
endmodule : tbpec_prescaler

// ### tb/tbpec_core_properties.sv
`timescale 1ns/1ps
module tbpec_core_properties
	import tbpec_pkg::*;
(
	input wire logic        I_CLK,
	input wire logic        I_RST_N,
	input wire logic [3:0]  I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic        I_EMU_SUSPEND,
	input wire logic [15:0] O_RDATA,
	input wire logic [15:0] O_TIMEBASE_COUNT,
	input wire logic        O_TIMEBASE_TICK,
	input wire logic        O_COUNT_UP,
	input wire logic        O_HALTED
);
	logic [15:0] ctl_q;
	logic [15:0] prd_q;
	logic [11:0] gap_q;
	logic [1:0]  seen_q;
	logic [11:0] ratio;
	logic [1:0]  emu;
	logic [1:0]  mode;
	assign emu = ctl_q[EMU_MSB:EMU_LSB];
	assign mode = ctl_q[MODE_MSB:MODE_LSB];
	assign ratio = (ctl_q[HSP_MSB:HSP_LSB] == 3'h0 ? 12'h001 :
		{8'h00, ctl_q[HSP_MSB:HSP_LSB], 1'b0}) << ctl_q[LSP_MSB:LSP_LSB];
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N)
			ctl_q <= CONTROL_RST;
		else if (I_WR && I_ADDR == ADDR_CONTROL)
			ctl_q <= I_WDATA;
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N)
			prd_q <= PERIOD_RST;
		else if (I_WR && I_ADDR == ADDR_PERIOD)
			prd_q <= I_WDATA;
	end
	// Two ticks after a control write pass before the gap is trusted
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N || (I_WR && I_ADDR == ADDR_CONTROL))
			seen_q <= 2'h0;
		else if (O_TIMEBASE_TICK && seen_q != 2'h2)
			seen_q <= seen_q + 2'h1;
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N || O_TIMEBASE_TICK)
			gap_q <= 12'h001;
		else
			gap_q <= gap_q + 12'h001;
	end
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_released;
		!I_EMU_SUSPEND [*8];
	endsequence
	a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == ZERO16)
		else $error("read data not idle");
	a_unmapped_zero: assert property ($past(I_RD) && $past(I_ADDR) >
		ADDR_STATUS |-> O_RDATA == ZERO16) else $error("unmapped read");
	a_tick_gap: assert property (O_TIMEBASE_TICK && seen_q == 2'h2
		|-> gap_q == ratio) else $error("tick spacing wrong");
	a_release_runs: assert property (s_released |-> !O_HALTED)
		else $error("halted without suspend");
	a_free_runs: assert property (ctl_q[EMU_MSB] [*3] |-> !O_HALTED)
		else $error("halted in free run");
	a_halt_frozen: assert property (O_HALTED && $past(O_HALTED) &&
		!$past(I_WR) |-> $stable(O_TIMEBASE_COUNT)) else $error("moved");
	a_up_stop_period: assert property (O_HALTED && emu == EMU_FULL_CYCLE
		&& mode == MODE_UP |-> O_TIMEBASE_COUNT == prd_q)
		else $error("up halt not at period");
	a_down_stop_zero: assert property (O_HALTED && emu == EMU_FULL_CYCLE
		&& (mode == MODE_DOWN || mode == MODE_UPDOWN)
		|-> O_TIMEBASE_COUNT == COUNT_ZERO) else $error("halt not at zero");
	a_up_dir_fixed: assert property ((mode == MODE_UP) [*8] |-> O_COUNT_UP)
		else $error("up mode counts down");
	a_down_dir_fixed: assert property ((mode == MODE_DOWN) [*8]
		|-> !O_COUNT_UP) else $error("down mode counts up");
endmodule : tbpec_core_properties

bind tbpec_core tbpec_core_properties u_props (.I_CLK(I_CLK),
	.I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.I_RD(I_RD), .I_EMU_SUSPEND(I_EMU_SUSPEND), .O_RDATA(O_RDATA),
	.O_TIMEBASE_COUNT(O_TIMEBASE_COUNT), .O_TIMEBASE_TICK(O_TIMEBASE_TICK),
	.O_COUNT_UP(O_COUNT_UP), .O_HALTED(O_HALTED));

// ### tb/tbpec_core_bench.sv
`timescale 1ns/1ps
module tbpec_core_bench;
	import tbpec_pkg::*;
	logic        I_CLK, I_RST_N, I_WR, I_RD, I_EMU_SUSPEND, I_SYNC_IN;
	logic [3:0]  I_ADDR;
	logic [15:0] I_WDATA, O_RDATA, O_TIMEBASE_COUNT, v;
	logic        O_TIMEBASE_TICK, O_COUNT_UP, O_HALTED;
	int          miscompares, n_compared, cyc, n;
	// {high code, low code, ratio}
	logic [21:0] tk [8] = '{{3'h0, 3'h0, 16'h0001}, {3'h1, 3'h2, 16'h0008},
		{3'h7, 3'h7, 16'h0700}, {3'h3, 3'h1, 16'h000c},
		{3'h5, 3'h6, 16'h0280}, {3'h2, 3'h3, 16'h0020},
		{3'h4, 3'h4, 16'h0080}, {3'h6, 3'h5, 16'h0180}};
	// {control, halted, count or ffff for any}
	logic [32:0] em [6] = '{{16'h0080, 1'b1, 16'hffff},
		{16'h4080, 1'b1, 16'h0014}, {16'h4081, 1'b1, 16'h0000},
		{16'h4082, 1'b1, 16'h0000}, {16'h8080, 1'b0, 16'hffff},
		{16'hc080, 1'b0, 16'hffff}};
	// {control, direction up, count centre}
	logic [32:0] ph [5] = '{{16'h0086, 1'b0, 16'h0064},
		{16'h2086, 1'b1, 16'h0064}, {16'h0084, 1'b1, 16'h0064},
		{16'h2085, 1'b0, 16'h0064}, {16'h0080, 1'b1, 16'h0004}};

	tbpec_core i_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
		.I_EMU_SUSPEND(I_EMU_SUSPEND), .I_SYNC_IN(I_SYNC_IN),
		.O_TIMEBASE_COUNT(O_TIMEBASE_COUNT), .O_TIMEBASE_TICK(O_TIMEBASE_TICK),
		.O_COUNT_UP(O_COUNT_UP), .O_HALTED(O_HALTED));

	task automatic end_of_test;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
		@(posedge I_CLK);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		@(posedge I_CLK);
		d = O_RDATA;
	endtask : rd

	initial begin
		I_CLK = 1'b0;
		forever #5 I_CLK = ~I_CLK;
	end
	// Whole run is well under this; a dead tick or halt lands here
	always @(posedge I_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		{I_RST_N, I_WR, I_RD, I_EMU_SUSPEND, I_SYNC_IN} = 5'h00;
		I_ADDR = 4'h0;
		I_WDATA = 16'h0000;
		repeat (5) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		@(posedge I_CLK);
		chk(O_TIMEBASE_COUNT, COUNT_RST);
		chk({15'h0, O_COUNT_UP}, 16'h0001);
		rd(ADDR_CONTROL, v);
		chk(v, CONTROL_RST);
		rd(4'h9, v);
		chk(v, ZERO16);
		$display("reset test done");
		foreach (tk[i]) begin
			wr(ADDR_CONTROL, {3'h0, tk[i][18:16], tk[i][21:19], 7'h03});
			repeat (3) begin
				@(posedge I_CLK);
				while (!O_TIMEBASE_TICK) @(posedge I_CLK);
			end
			n = 0;
			do begin
				@(posedge I_CLK);
				n++;
			end while (!O_TIMEBASE_TICK);
			chk(16'(n), tk[i][15:0]);
		end
		$display("prescale test done");
		wr(ADDR_PERIOD, 16'h00c8);
		wr(ADDR_PHASE, 16'h0064);
		foreach (ph[i]) begin
			wr(ADDR_CONTROL, ph[i][32:17]);
			wr(ADDR_COUNT, 16'h0000);
			I_SYNC_IN <= 1'b1;
			repeat (4) @(posedge I_CLK);
			I_SYNC_IN <= 1'b0;
			repeat (2) @(posedge I_CLK);
			chk({15'h0, O_COUNT_UP}, {15'h0, ph[i][16]});
			chk({15'h0, O_TIMEBASE_COUNT + 16'h0004 - ph[i][15:0] <= 16'h0008},
				16'h0001);
		end
		$display("phase test done");
		wr(ADDR_PERIOD, 16'h0014);
		foreach (em[i]) begin
			wr(ADDR_CONTROL, em[i][32:17]);
			wr(ADDR_COUNT, 16'h0003);
			I_EMU_SUSPEND <= 1'b1;
			repeat (100) @(posedge I_CLK);
			chk({15'h0, O_HALTED}, {15'h0, em[i][16]});
			if (em[i][15:0] != 16'hffff)
				chk(O_TIMEBASE_COUNT, em[i][15:0]);
			rd(ADDR_STATUS, v);
			chk({15'h0, v[2]}, {15'h0, em[i][16]});
			I_EMU_SUSPEND <= 1'b0;
			repeat (10) @(posedge I_CLK);
			chk({15'h0, O_HALTED}, 16'h0000);
		end
		$display("suspend test done");
		end_of_test();
	end
endmodule : tbpec_core_bench
